// File: pcd_cfg.svh
// register offsets, field positions, reset values and widths for the pin change detector
`ifndef PCD_CFG_SVH
`define PCD_CFG_SVH
`define PCD_OFF_RISE_A 8'h00
`define PCD_OFF_FALL_A 8'h04
`define PCD_OFF_RISE_B 8'h08
`define PCD_OFF_FALL_B 8'h0C
`define PCD_OFF_FLAG_A 8'h10
`define PCD_OFF_FLAG_B 8'h14
`define PCD_OFF_CTRL 8'h18
`define PCD_OFF_ISTAT 8'h1C
`define PCD_OFF_IMASK 8'h20
`define PCD_CTRL_MASTER_BIT 0
`define PCD_CTRL_SUMMARY_BIT 1
`define PCD_ISTAT_A_BIT 0
`define PCD_ISTAT_B_BIT 1
`define PCD_ISTAT_W 2
`define PCD_ENABLE_RST 8'h00
`define PCD_ISTAT_RST 2'h0
`define PCD_PORT_W 6
`define PCD_PRIME_W 2
`define PCD_PRIME_DONE 2'h3
`endif

// File: pcd_pkg.sv
// types shared by the pin change detector
package pcd_pkg;
  typedef enum logic [3:0] {
    PCD_R_RISE_A = 4'h0,
    PCD_R_FALL_A = 4'h1,
    PCD_R_RISE_B = 4'h2,
    PCD_R_FALL_B = 4'h3,
    PCD_R_FLAG_A = 4'h4,
    PCD_R_FLAG_B = 4'h5,
    PCD_R_CTRL = 4'h6,
    PCD_R_ISTAT = 4'h7,
    PCD_R_IMASK = 4'h8,
    PCD_R_NONE = 4'hF
  } pcd_reg_t;
endpackage

// File: pcd_top.sv
// pin change detector with apb register access, interrupt and wake outputs
//
// Functional notes
// - each pin of either port is an independent change source with its own enables.
// - each pin has a rising-edge detector enabled by its bit in the rise enable register.
// - each pin has a falling-edge detector enabled by its bit in the fall enable register.
// - with both enables set a pin reports edges of either polarity.
// - an enabled edge sets the pin flag, and the change interrupt rises only with the master enable.
// - with the master enable clear, edges still set flags but no interrupt is raised.
// - the read-only summary flag is the OR of every pin flag of both ports.
// - writing zero to a pin flag bit clears it.
// - an edge arriving during a flag write leaves that flag set whatever was written.
// - a detected change wakes the device from sleep when the master enable is set.
// - flags are updated before the wake indication is given.
// - port a rise enables sit in bits 5..0, reset to zero, and bits 7..6 read zero.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "pcd_cfg.svh"
module pcd_top #(
  parameter int PA_W = `PCD_PORT_W,
  parameter int PB_W = `PCD_PORT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [PA_W-1:0] pin_a_in,
  input wire logic [PB_W-1:0] pin_b_in,
  input wire logic sleep_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic change_irq_out,
  output logic change_irq_summary_flag_out,
  output logic wake_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic pcd_pkg::pcd_reg_t decode(input logic [7:0] a);
    unique case (a)
      `PCD_OFF_RISE_A: decode = pcd_pkg::PCD_R_RISE_A;
      `PCD_OFF_FALL_A: decode = pcd_pkg::PCD_R_FALL_A;
      `PCD_OFF_RISE_B: decode = pcd_pkg::PCD_R_RISE_B;
      `PCD_OFF_FALL_B: decode = pcd_pkg::PCD_R_FALL_B;
      `PCD_OFF_FLAG_A: decode = pcd_pkg::PCD_R_FLAG_A;
      `PCD_OFF_FLAG_B: decode = pcd_pkg::PCD_R_FLAG_B;
      `PCD_OFF_CTRL: decode = pcd_pkg::PCD_R_CTRL;
      `PCD_OFF_ISTAT: decode = pcd_pkg::PCD_R_ISTAT;
      `PCD_OFF_IMASK: decode = pcd_pkg::PCD_R_IMASK;
      default: decode = pcd_pkg::PCD_R_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [PA_W-1:0] sync1_a_reg, sync2_a_reg, prev_a_reg;
  logic [PB_W-1:0] sync1_b_reg, sync2_b_reg, prev_b_reg;
  logic [`PCD_PRIME_W-1:0] prime_reg, prime_next;
  logic [PA_W-1:0] rise_a_reg, rise_a_next, fall_a_reg, fall_a_next;
  logic [PB_W-1:0] rise_b_reg, rise_b_next, fall_b_reg, fall_b_next;
  logic [PA_W-1:0] flag_a_reg, flag_a_next;
  logic [PB_W-1:0] flag_b_reg, flag_b_next;
  logic master_reg, master_next;
  logic summary_reg, summary_next;
  logic [`PCD_ISTAT_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [PA_W-1:0] edge_a;
  logic [PB_W-1:0] edge_b;
  logic primed;
  logic setup, access, wr;
  pcd_pkg::pcd_reg_t sel;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  // prime counter keeps a pin that is already high at reset from
  // looking like a rising edge before prev holds a real sample
  assign primed = (prime_reg == `PCD_PRIME_DONE);
  // rise and fall detectors are independent, both may be on
  assign edge_a = primed ? ((sync2_a_reg & ~prev_a_reg & rise_a_reg)
                  | (~sync2_a_reg & prev_a_reg & fall_a_reg)) : '0;
  assign edge_b = primed ? ((sync2_b_reg & ~prev_b_reg & rise_b_reg)
                  | (~sync2_b_reg & prev_b_reg & fall_b_reg)) : '0;

  always_comb begin
    prime_next = primed ? prime_reg : prime_reg + 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_a_reg <= '0;
      sync2_a_reg <= '0;
      prev_a_reg <= '0;
      sync1_b_reg <= '0;
      sync2_b_reg <= '0;
      prev_b_reg <= '0;
      prime_reg <= '0;
    end else begin
      sync1_a_reg <= pin_a_in;
      sync2_a_reg <= sync1_a_reg;
      prev_a_reg <= sync2_a_reg;
      sync1_b_reg <= pin_b_in;
      sync2_b_reg <= sync1_b_reg;
      prev_b_reg <= sync2_b_reg;
      prime_reg <= prime_next;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and register file
  // ----------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign sel = decode(paddr_in);
  assign wr = access & pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = access & (sel == pcd_pkg::PCD_R_NONE);
  assign prdata_out = prdata_reg;

  always_comb begin
    rise_a_next = rise_a_reg;
    fall_a_next = fall_a_reg;
    rise_b_next = rise_b_reg;
    fall_b_next = fall_b_reg;
    master_next = master_reg;
    imask_next = imask_reg;
    flag_a_next = flag_a_reg;
    flag_b_next = flag_b_reg;
    istat_next = istat_reg;
    if (wr) begin
      unique case (sel)
        pcd_pkg::PCD_R_RISE_A: rise_a_next = pwdata_in[PA_W-1:0];
        pcd_pkg::PCD_R_FALL_A: fall_a_next = pwdata_in[PA_W-1:0];
        pcd_pkg::PCD_R_RISE_B: rise_b_next = pwdata_in[PB_W-1:0];
        pcd_pkg::PCD_R_FALL_B: fall_b_next = pwdata_in[PB_W-1:0];
        // a write can only clear: software cannot fake a change
        pcd_pkg::PCD_R_FLAG_A: flag_a_next = flag_a_reg & pwdata_in[PA_W-1:0];
        pcd_pkg::PCD_R_FLAG_B: flag_b_next = flag_b_reg & pwdata_in[PB_W-1:0];
        pcd_pkg::PCD_R_CTRL: master_next = pwdata_in[`PCD_CTRL_MASTER_BIT];
        pcd_pkg::PCD_R_ISTAT: istat_next = istat_reg & ~pwdata_in[`PCD_ISTAT_W-1:0];
        pcd_pkg::PCD_R_IMASK: imask_next = pwdata_in[`PCD_ISTAT_W-1:0];
        default: ;
      endcase
    end
    // edges are merged after the write so a new edge always survives
    flag_a_next = flag_a_next | edge_a;
    flag_b_next = flag_b_next | edge_b;
    // event status only records edges seen while the master switch is on
    if (master_reg && (edge_a != '0)) begin
      istat_next[`PCD_ISTAT_A_BIT] = 1'b1;
    end
    if (master_reg && (edge_b != '0)) begin
      istat_next[`PCD_ISTAT_B_BIT] = 1'b1;
    end
    summary_next = (|flag_a_next) | (|flag_b_next);
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      unique case (sel)
        pcd_pkg::PCD_R_RISE_A: prdata_next[PA_W-1:0] = rise_a_reg;
        pcd_pkg::PCD_R_FALL_A: prdata_next[PA_W-1:0] = fall_a_reg;
        pcd_pkg::PCD_R_RISE_B: prdata_next[PB_W-1:0] = rise_b_reg;
        pcd_pkg::PCD_R_FALL_B: prdata_next[PB_W-1:0] = fall_b_reg;
        pcd_pkg::PCD_R_FLAG_A: prdata_next[PA_W-1:0] = flag_a_reg;
        pcd_pkg::PCD_R_FLAG_B: prdata_next[PB_W-1:0] = flag_b_reg;
        pcd_pkg::PCD_R_CTRL: begin
          prdata_next[`PCD_CTRL_MASTER_BIT] = master_reg;
          prdata_next[`PCD_CTRL_SUMMARY_BIT] = summary_reg;
        end
        pcd_pkg::PCD_R_ISTAT: prdata_next[`PCD_ISTAT_W-1:0] = istat_reg;
        pcd_pkg::PCD_R_IMASK: prdata_next[`PCD_ISTAT_W-1:0] = imask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rise_a_reg <= '0;
      fall_a_reg <= '0;
      rise_b_reg <= '0;
      fall_b_reg <= '0;
      flag_a_reg <= '0;
      flag_b_reg <= '0;
      master_reg <= 1'b0;
      summary_reg <= 1'b0;
      istat_reg <= `PCD_ISTAT_RST;
      imask_reg <= `PCD_ISTAT_RST;
      prdata_reg <= 32'h0000_0000;
    end else begin
      rise_a_reg <= rise_a_next;
      fall_a_reg <= fall_a_next;
      rise_b_reg <= rise_b_next;
      fall_b_reg <= fall_b_next;
      flag_a_reg <= flag_a_next;
      flag_b_reg <= flag_b_next;
      master_reg <= master_next;
      summary_reg <= summary_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and wake
  // ----------------------------------------------------------------
  // wake is built from the flag summary, so flags are already valid
  // when wake rises
  assign change_irq_summary_flag_out = summary_reg;
  assign change_irq_out = master_reg & summary_reg;
  assign wake_out = sleep_in & master_reg & summary_reg;
  assign irq_out = |(istat_reg & imask_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_edge_sets_flag;
    @(posedge clk_in) disable iff (rst_in)
    (edge_a != '0) |=> ((flag_a_reg & $past(edge_a)) == $past(edge_a));
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("edge did not set flag");

  property p_no_spurious_flag;
    @(posedge clk_in) disable iff (rst_in)
    ##1 ((flag_b_reg & ~$past(flag_b_reg) & ~$past(edge_b)) == '0);
  endproperty
  a_no_spurious_flag: assert property (p_no_spurious_flag) else $error("flag set without edge");

  property p_summary;
    @(posedge clk_in) disable iff (rst_in)
    summary_reg == ((|flag_a_reg) | (|flag_b_reg));
  endproperty
  a_summary: assert property (p_summary) else $error("summary not OR of flags");

  property p_clear;
    @(posedge clk_in) disable iff (rst_in)
    (wr && sel == pcd_pkg::PCD_R_FLAG_A && edge_a == '0)
      |=> (flag_a_reg == ($past(flag_a_reg) & $past(pwdata_in[PA_W-1:0])));
  endproperty
  a_clear: assert property (p_clear) else $error("flag write did not clear");

  property p_edge_wins;
    @(posedge clk_in) disable iff (rst_in)
    (wr && sel == pcd_pkg::PCD_R_FLAG_B && edge_b != '0)
      |=> ((flag_b_reg & $past(edge_b)) == $past(edge_b));
  endproperty
  a_edge_wins: assert property (p_edge_wins) else $error("edge lost during clear");

  property p_irq_gate;
    @(posedge clk_in) disable iff (rst_in)
    change_irq_out |-> (master_reg && summary_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without master enable");

  property p_irq_follows;
    @(posedge clk_in) disable iff (rst_in)
    (master_reg && edge_a != '0 && !(wr && sel == pcd_pkg::PCD_R_CTRL)) |=> change_irq_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing after edge");

  property p_wake;
    @(posedge clk_in) disable iff (rst_in)
    (sleep_in && master_reg && (edge_a != '0 || edge_b != '0)) ##1 (sleep_in && master_reg) |-> wake_out && summary_reg;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after change");

  property p_rise_a_read;
    @(posedge clk_in) disable iff (rst_in)
    (setup && sel == pcd_pkg::PCD_R_RISE_A) |=> (prdata_out == 32'($past(rise_a_reg)));
  endproperty
  a_rise_a_read: assert property (p_rise_a_read) else $error("rise enable readback wrong");

  property p_sync_depth;
    @(posedge clk_in) disable iff (rst_in)
    (edge_a != '0) |-> ($past(pin_a_in, 2) != $past(pin_a_in, 3));
  endproperty
  a_sync_depth: assert property (p_sync_depth) else $error("edge not from synchronised pin");

endmodule

// File: pcd_pins.sv
// model of the external signals on the port pins
`timescale 1ns/100ps
module pcd_pins #(
  parameter int PA_W = 6,
  parameter int PB_W = 6
) (
  input wire logic clk_in,
  output logic [PA_W-1:0] pin_a_out,
  output logic [PB_W-1:0] pin_b_out
);
  initial begin
    pin_a_out = '0;
    pin_b_out = '0;
  end
  // levels are held for several cycles so that no change is shorter than one sample
  task automatic drive(input logic [PA_W-1:0] a, input logic [PB_W-1:0] b);
    @(posedge clk_in);
    pin_a_out <= a;
    pin_b_out <= b;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// File: pcd_top_bench.sv
// self-checking bench for the pin change detector
`timescale 1ns/100ps
`include "pcd_cfg.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module pcd_top_bench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk_in, rst_in, sleep_in, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, change_irq, summary, wake, irq, e;
  logic [5:0] pin_a, pin_b;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  pcd_pins u_pcd_pins (.clk_in(clk_in), .pin_a_out(pin_a), .pin_b_out(pin_b));
  pcd_top u_pcd_top (.clk_in(clk_in), .rst_in(rst_in), .pin_a_in(pin_a), .pin_b_in(pin_b),
    .sleep_in(sleep_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .change_irq_out(change_irq), .change_irq_summary_flag_out(summary),
    .wake_out(wake), .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // a hang ends the run as a failure instead of running forever
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", ex, r)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    sleep_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    // edge detection is blind while the synchroniser primes
    repeat (5) @(posedge clk_in);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
    wr(`PCD_OFF_RISE_A, 32'hFFFF_FFFF);
    rd(`PCD_OFF_RISE_A, 32'h0000_003F);
    $display("test reset_values done");
    wr(`PCD_OFF_RISE_B, 32'h0000_0008);
    wr(`PCD_OFF_FALL_B, 32'h0000_000C);
    u_pcd_pins.drive(6'h01, 6'h0C);
    rd(`PCD_OFF_FLAG_A, 32'h0000_0001);
    rd(`PCD_OFF_FLAG_B, 32'h0000_0008);
    `CHK("summary", 1'b1, summary)
    `CHK("change_irq", 1'b0, change_irq)
    rd(`PCD_OFF_ISTAT, 32'h0);
    u_pcd_pins.drive(6'h00, 6'h00);
    rd(`PCD_OFF_FLAG_A, 32'h0000_0001);
    rd(`PCD_OFF_FLAG_B, 32'h0000_000C);
    $display("test edges done");
    wr(`PCD_OFF_FLAG_A, 32'hFFFF_FFFE);
    rd(`PCD_OFF_FLAG_A, 32'h0);
    wr(`PCD_OFF_FLAG_B, 32'hFFFF_FFF7);
    rd(`PCD_OFF_FLAG_B, 32'h0000_0004);
    `CHK("summary", 1'b1, summary)
    wr(`PCD_OFF_FLAG_B, 32'h0);
    // the write lands on the edge the task returns on, so let the flops settle
    @(negedge clk_in);
    `CHK("summary", 1'b0, summary)
    $display("test clear done");
    wr(`PCD_OFF_CTRL, 32'h1);
    wr(`PCD_OFF_IMASK, 32'h1);
    u_pcd_pins.drive(6'h02, 6'h00);
    `CHK("change_irq", 1'b1, change_irq)
    `CHK("irq", 1'b1, irq)
    rd(`PCD_OFF_CTRL, 32'h3);
    rd(`PCD_OFF_ISTAT, 32'h1);
    wr(`PCD_OFF_IMASK, 32'h0);
    @(negedge clk_in);
    `CHK("irq", 1'b0, irq)
    wr(`PCD_OFF_ISTAT, 32'h1);
    rd(`PCD_OFF_ISTAT, 32'h0);
    $display("test interrupt done");
    wr(`PCD_OFF_FLAG_A, 32'h0);
    sleep_in <= 1'b1;
    @(posedge clk_in);
    `CHK("wake", 1'b0, wake)
    fork
      u_pcd_pins.drive(6'h00, 6'h08);
      begin
        for (int n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clk_in);
        `CHK("wake", 1'b1, wake)
        `CHK("summary", 1'b1, summary)
      end
    join
    sleep_in <= 1'b0;
    rd(`PCD_OFF_FLAG_B, 32'h0000_0008);
    rd(`PCD_OFF_ISTAT, 32'h2);
    $display("test sleep done");
    // the clear commits on the same edge at which the falling edge of pin b3 is seen
    fork
      u_pcd_pins.drive(6'h00, 6'h00);
      begin
        @(posedge clk_in);
        wr(`PCD_OFF_FLAG_B, 32'h0);
      end
    join
    rd(`PCD_OFF_FLAG_B, 32'h0000_0008);
    `CHK("summary", 1'b1, summary)
    $display("test clear_race done");
    wr(8'h40, 32'hFFFF_FFFF);
    `CHK("pslverr", 1'b1, e)
    rd(8'h40, 32'h0);
    `CHK("pslverr", 1'b1, e)
    `CHK("pready", 1'b1, pready)
    $display("test unmapped done");
    wrap_up();
  end
endmodule
